// >>> pmm_pkg.sv
// Purpose: shared constants for the program memory block
// Assumes: 16-bit steps, 2K-step pages, 12-bit program counter
// Notes: sizes are selected per variant at the top module
package pmm_pkg;
  // ----------------------------------------
  // memory geometry
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int PC_W = 12;
  localparam int PAGE_STEPS = 2048;
  localparam int BYTE_W = 8;
  localparam int MODE_W = 4;
  localparam logic [PC_W-1:0] PAGE0_LAST = 12'h7FF;
  localparam int SIZE_SMALL = 1024;
  localparam int SIZE_MID = 2048;
  localparam int SIZE_FULL = 4096;
  // ----------------------------------------
  // vectors
  // ----------------------------------------
  localparam logic [PC_W-1:0] VEC_RESET = 12'h000;
  localparam logic [PC_W-1:0] VEC_SERIAL = 12'h001;
  localparam logic [PC_W-1:0] VEC_INTERVAL = 12'h002;
  localparam logic [PC_W-1:0] VEC_TIMER1 = 12'h003;
  localparam logic [PC_W-1:0] VEC_TIMER0 = 12'h004;
  localparam logic [PC_W-1:0] VEC_EXTERNAL = 12'h005;
  localparam int NUM_IRQ = 5;
  // ----------------------------------------
  // opcode bases for direct branches
  // ----------------------------------------
  localparam logic [WORD_W-1:0] BR_PAGE0_BASE = 16'hC000;
  localparam logic [WORD_W-1:0] BR_PAGE1_BASE = 16'hD000;
  localparam logic [WORD_W-1:0] BR_MASK = 16'hF800;
  localparam logic [WORD_W-1:0] BR_PAGE_BIT = 16'h1000;
  // ----------------------------------------
  // write/verify mode codes (plain defaults)
  // ----------------------------------------
  localparam logic [MODE_W-1:0] MODE_IDLE = 4'h0;
  localparam logic [MODE_W-1:0] MODE_CLEAR = 4'h1;
  localparam logic [MODE_W-1:0] MODE_WRITE = 4'h2;
  localparam logic [MODE_W-1:0] MODE_VERIFY = 4'h3;
  localparam logic RESET_HALF = 1'b0;
  // ----------------------------------------
  // fetch unit operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_NEXT, OP_BRANCH_DIRECT, OP_BRANCH_IND, OP_CALL_DIRECT, OP_CALL_IND, OP_TABLE, OP_IRQ, OP_HOLD
  } pmm_op_type;
endpackage

// >>> pmm_wv_port.sv
// Purpose: write/verify byte port of the program memory
// Assumes: mode and clock inputs already synchronised
// Notes: one word passes as low byte then high byte
`timescale 1ns/10ps
module pmm_wv_port
  import pmm_pkg::*;
#(
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [pmm_pkg::MODE_W-1:0] mode,
  input wire logic clk_rise,
  input wire logic [pmm_pkg::BYTE_W-1:0] bus_in,
  input wire logic [pmm_pkg::WORD_W-1:0] rd_word,
  output logic [AW-1:0] addr,
  output logic half,
  output logic wr_en,
  output logic [pmm_pkg::WORD_W-1:0] wr_word,
  output logic [pmm_pkg::BYTE_W-1:0] bus_out,
  output logic bus_oe
);
  logic [AW-1:0] addr_r, addr_nxt;
  logic half_r, half_nxt;
  logic [BYTE_W-1:0] low_r, low_nxt;
  logic [BYTE_W-1:0] out_r, out_nxt;
  logic oe_r, oe_nxt;
  logic wr_r, wr_nxt;
  // word and address held apart so the address advance cannot disturb the write
  logic [AW-1:0] wr_addr_r, wr_addr_nxt;
  logic [WORD_W-1:0] wr_word_r, wr_word_nxt;
  logic active;

  if (AW < 1 || AW > PC_W) begin
    $error("AW must lie between 1 and 12");
  end

  assign active = (mode == MODE_WRITE) || (mode == MODE_VERIFY);

  always_comb begin
    addr_nxt = addr_r;
    half_nxt = half_r;
    low_nxt = low_r;
    wr_nxt = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_word_nxt = wr_word_r;
    oe_nxt = (mode == MODE_VERIFY);
    out_nxt = half_r ? rd_word[WORD_W-1:BYTE_W] : rd_word[BYTE_W-1:0];
    if (mode == MODE_CLEAR) begin
      addr_nxt = '0;
      half_nxt = RESET_HALF;
    end else if (active && clk_rise) begin
      // the address moves only after the second half
      half_nxt = ~half_r;
      if (!half_r) begin
        low_nxt = bus_in;
      end else begin
        addr_nxt = addr_r + 1'b1;
        wr_addr_nxt = addr_r;
        wr_word_nxt = {bus_in, low_r};
        wr_nxt = (mode == MODE_WRITE);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_r <= '0;
      half_r <= RESET_HALF;
      low_r <= '0;
      out_r <= '0;
      oe_r <= 1'b0;
      wr_r <= 1'b0;
      wr_addr_r <= '0;
      wr_word_r <= '0;
    end else begin
      addr_r <= addr_nxt;
      half_r <= half_nxt;
      low_r <= low_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      wr_r <= wr_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_word_r <= wr_word_nxt;
    end
  end

  assign addr = wr_r ? wr_addr_r : addr_r;
  assign half = half_r;
  assign wr_en = wr_r;
  assign wr_word = wr_word_r;
  assign bus_out = out_r;
  assign bus_oe = oe_r;

  property p_adv;
    @(posedge clk) disable iff (rst)
      (active && clk_rise && half_r && mode != MODE_CLEAR) |=> (addr_r == $past(addr_r) + 1'b1);
  endproperty
  a_adv: assert property (p_adv) else $error("address did not advance");

  property p_hold;
    @(posedge clk) disable iff (rst)
      (active && clk_rise && !half_r) |=> (addr_r == $past(addr_r));
  endproperty
  a_hold: assert property (p_hold) else $error("address moved after first half");

  property p_oe;
    @(posedge clk) disable iff (rst) (mode == MODE_WRITE) |=> !bus_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("byte bus driven during write");
endmodule

// >>> pmm_core.sv
// Purpose: program memory, fetch addressing and write/verify port
// Assumes: pins from the programmer are asynchronous to MCLK
// Notes: memory is flip-flop storage sized by DEPTH
//
// Notes on behaviour
// - every location holds one 16-bit word and reads return all 16 bits.
// - memory is split into 2K-step pages, page 0 at the bottom, page 1 next.
// - depth is 1024, 2048 or 4096 words from address 0 upward, by variant.
// - the fetch address comes from the program counter only.
// - reset and interrupt vectors sit at the lowest addresses.
// - a direct call reaches only 0000H to 07FFH.
// - branches, indirect calls and table reads reach the whole memory.
// - words pass on an 8-bit two-way bus, driven in by writes, out by verifies.
// - every second address-update clock pulse advances the internal address.
// - reset starts at 0000H; serial, interval, timer 1, timer 0, external go to 1-5.
// - direct branch opcodes are C000H based for page 0, D000H for page 1.
// - a table read takes two cycles and loads the full word into the buffer.
`timescale 1ns/10ps
module pmm_core
  import pmm_pkg::*;
#(
  parameter int DEPTH = pmm_pkg::SIZE_FULL
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire pmm_pkg::pmm_op_type OP,
  input wire logic [pmm_pkg::WORD_W-1:0] OPCODE,
  input wire logic [pmm_pkg::PC_W-1:0] ADDR_POINTER_REG,
  input wire logic [2:0] IRQ_SEL,
  input wire logic [pmm_pkg::MODE_W-1:0] PROG_MODE_SELECT,
  input wire logic PROG_CLK,
  input wire logic [pmm_pkg::BYTE_W-1:0] PROG_BYTE_BUS_IN,
  output logic [pmm_pkg::BYTE_W-1:0] PROG_BYTE_BUS_OUT,
  output logic PROG_BYTE_BUS_OE,
  output logic [pmm_pkg::PC_W-1:0] PC,
  output logic [pmm_pkg::WORD_W-1:0] INSTR,
  output logic [pmm_pkg::WORD_W-1:0] TRANSFER_BUFFER,
  output logic TABLE_BUSY,
  output logic CALL_REFUSED
);
  import pmm_pkg::*;

  localparam int AW = $clog2(DEPTH);

  if (DEPTH != SIZE_SMALL && DEPTH != SIZE_MID && DEPTH != SIZE_FULL) begin
    $error("DEPTH must be 1024, 2048 or 4096");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // clips any address to the implemented range
  function automatic logic [PC_W-1:0] clip(input logic [PC_W-1:0] a);
    logic [PC_W-1:0] m;
    m = PC_W'(DEPTH - 1);
    return a & m;
  endfunction

  // storage index of a clipped address
  function automatic logic [AW-1:0] idx(input logic [PC_W-1:0] a);
    logic [PC_W-1:0] c;
    c = clip(a);
    return c[AW-1:0];
  endfunction

  // direct branch target: low 11 bits plus page bit from opcode
  function automatic logic [PC_W-1:0] br_target(input logic [WORD_W-1:0] op);
    logic [PC_W-1:0] t;
    t = {((op & BR_MASK) == BR_PAGE1_BASE) ? 1'b1 : 1'b0, op[10:0]};
    return t;
  endfunction

  function automatic logic [PC_W-1:0] vec(input logic [2:0] s);
    logic [PC_W-1:0] v;
    unique case (s)
      3'h0: v = VEC_SERIAL;
      3'h1: v = VEC_INTERVAL;
      3'h2: v = VEC_TIMER1;
      3'h3: v = VEC_TIMER0;
      default: v = VEC_EXTERNAL;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two stages so metastability stays off the mode decode
  logic [MODE_W-1:0] mode_s1_r, mode_s2_r;
  logic clk_s1_r, clk_s2_r, clk_s3_r;
  logic [BYTE_W-1:0] bus_s1_r, bus_s2_r;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mode_s1_r <= MODE_IDLE;
      mode_s2_r <= MODE_IDLE;
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
      bus_s1_r <= '0;
      bus_s2_r <= '0;
    end else begin
      mode_s1_r <= PROG_MODE_SELECT;
      mode_s2_r <= mode_s1_r;
      clk_s1_r <= PROG_CLK;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      bus_s1_r <= PROG_BYTE_BUS_IN;
      bus_s2_r <= bus_s1_r;
    end
  end

  logic clk_rise;
  assign clk_rise = clk_s2_r & ~clk_s3_r;

  // ----------------------------------------
  // storage and write/verify port
  // ----------------------------------------
  logic [WORD_W-1:0] mem [DEPTH];
  logic [AW-1:0] wv_addr;
  logic wv_wr;
  logic [WORD_W-1:0] wv_word;

  pmm_wv_port #(.AW(AW)) u_wv (
    .clk(MCLK),
    .rst(RST),
    .mode(mode_s2_r),
    .clk_rise(clk_rise),
    .bus_in(bus_s2_r),
    .rd_word(mem[wv_addr]),
    .addr(wv_addr),
    .half(),
    .wr_en(wv_wr),
    .wr_word(wv_word),
    .bus_out(PROG_BYTE_BUS_OUT),
    .bus_oe(PROG_BYTE_BUS_OE)
  );

  // no reset: contents survive reset like a programmed array
  always_ff @(posedge MCLK) begin
    if (wv_wr) begin
      mem[wv_addr] <= wv_word;
    end
  end

  // ----------------------------------------
  // program counter and fetch
  // ----------------------------------------
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [WORD_W-1:0] instr_r, instr_nxt;
  logic [WORD_W-1:0] buf_r, buf_nxt;
  logic tbl_r, tbl_nxt;
  logic ref_r, ref_nxt;
  logic [PC_W-1:0] tgt;

  always_comb begin
    pc_nxt = pc_r;
    tbl_nxt = 1'b0;
    ref_nxt = 1'b0;
    buf_nxt = buf_r;
    tgt = pc_r + 1'b1;
    if (tbl_r) begin
      // second cycle of a table read
      buf_nxt = mem[idx(ADDR_POINTER_REG)];
    end else begin
      unique case (OP)
        OP_NEXT: tgt = pc_r + 1'b1;
        OP_BRANCH_DIRECT: tgt = br_target(OPCODE);
        OP_BRANCH_IND, OP_CALL_IND: tgt = ADDR_POINTER_REG;
        OP_CALL_DIRECT: begin
          // page 0 only
          if (OPCODE[10:0] <= PAGE0_LAST[10:0]) begin
            tgt = {1'b0, OPCODE[10:0]};
          end else begin
            tgt = pc_r;
            ref_nxt = 1'b1;
          end
        end
        OP_TABLE: begin
          tgt = pc_r;
          tbl_nxt = 1'b1;
        end
        OP_IRQ: tgt = vec(IRQ_SEL);
        OP_HOLD: tgt = pc_r;
      endcase
      pc_nxt = clip(tgt);
    end
    if (tbl_r) begin
      pc_nxt = clip(pc_r + 1'b1);
    end
    instr_nxt = mem[idx(pc_nxt)];
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pc_r <= VEC_RESET;
      instr_r <= '0;
      buf_r <= '0;
      tbl_r <= 1'b0;
      ref_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      instr_r <= instr_nxt;
      buf_r <= buf_nxt;
      tbl_r <= tbl_nxt;
      ref_r <= ref_nxt;
    end
  end

  assign PC = pc_r;
  assign INSTR = instr_r;
  assign TRANSFER_BUFFER = buf_r;
  assign TABLE_BUSY = tbl_r;
  assign CALL_REFUSED = ref_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_range;
    @(posedge MCLK) disable iff (RST) (PC | PC_W'(DEPTH - 1)) == PC_W'(DEPTH - 1);
  endproperty
  a_range: assert property (p_range) else $error("pc left memory range");

  property p_call;
    @(posedge MCLK) disable iff (RST) (!tbl_r && OP == OP_CALL_DIRECT) |=> PC <= PAGE0_LAST;
  endproperty
  a_call: assert property (p_call) else $error("direct call left page 0");

  property p_tbl;
    @(posedge MCLK) disable iff (RST) (!tbl_r && OP == OP_TABLE) |=> TABLE_BUSY ##1 !TABLE_BUSY;
  endproperty
  a_tbl: assert property (p_tbl) else $error("table read not two cycles");

  property p_buf;
    @(posedge MCLK) disable iff (RST)
      tbl_r |=> TRANSFER_BUFFER == $past(mem[idx(ADDR_POINTER_REG)]);
  endproperty
  a_buf: assert property (p_buf) else $error("buffer missed table word");

  property p_vec;
    @(posedge MCLK) disable iff (RST)
      (!tbl_r && OP == OP_IRQ) |=> PC == $past(IRQ_SEL) + 3'h1 || PC == VEC_EXTERNAL;
  endproperty
  a_vec: assert property (p_vec) else $error("wrong interrupt vector");

  property p_ind;
    @(posedge MCLK) disable iff (RST)
      (!tbl_r && OP == OP_BRANCH_IND) |=> PC == clip($past(ADDR_POINTER_REG));
  endproperty
  a_ind: assert property (p_ind) else $error("indirect target wrong");

  property p_fetch;
    // first edge after reset still shows the reset zero, the edge after a write the old word
    @(posedge MCLK) disable iff (RST)
      (!$past(RST) && !$past(wv_wr)) |-> INSTR === mem[PC[AW-1:0]];
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not from pc");

  property p_brpg;
    @(posedge MCLK) disable iff (RST)
      (!tbl_r && OP == OP_BRANCH_DIRECT && (OPCODE & BR_MASK) == BR_PAGE1_BASE
        && DEPTH == SIZE_FULL) |=> PC[11];
  endproperty
  a_brpg: assert property (p_brpg) else $error("page 1 branch missed page");

  c_tbl: cover property (@(posedge MCLK) disable iff (RST) TABLE_BUSY);
  c_ref: cover property (@(posedge MCLK) disable iff (RST) CALL_REFUSED);
  c_oe: cover property (@(posedge MCLK) disable iff (RST) PROG_BYTE_BUS_OE);
  c_irq: cover property (@(posedge MCLK) disable iff (RST) !tbl_r && OP == OP_IRQ);
endmodule

// >>> pmm_prog_model.sv
// Purpose: programmer model for the write/verify byte port
// Assumes: driven from the MCLK domain, levels held 3 cycles
// Notes: a released bus shows the inverse of its last byte
`timescale 1ns/10ps
module pmm_prog_model
  import pmm_pkg::*;
(
  input wire logic clk,
  output logic [pmm_pkg::MODE_W-1:0] mode,
  output logic pclk,
  output logic [pmm_pkg::BYTE_W-1:0] drv
);
  // ----------------------------------------
  // programmer sequences
  // ----------------------------------------
  initial begin
    mode = MODE_IDLE;
    pclk = 1'b0;
    drv = 8'h00;
  end
  task automatic set_mode(input logic [MODE_W-1:0] m);
    @(posedge clk);
    mode <= m;
    repeat (6) @(posedge clk);
  endtask
  // data leads the rise by one cycle so the sync stages see it settled
  task automatic pulse(input logic [BYTE_W-1:0] b, input bit own);
    @(posedge clk);
    drv <= own ? b : ~drv;
    @(posedge clk);
    pclk <= 1'b1;
    repeat (3) @(posedge clk);
    pclk <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic put_word(input logic [WORD_W-1:0] w);
    pulse(w[7:0], 1'b1);
    pulse(w[15:8], 1'b1);
  endtask
endmodule

// >>> testbench.sv
// Purpose: self-checking bench for the program memory block
// Assumes: full 4096-word variant, every location written first
// Notes: rows cover fetch addressing, hand tests the rest
`timescale 1ns/10ps
module testbench;
  import pmm_pkg::*;
  typedef struct {
    pmm_op_type op;
    logic [WORD_W-1:0] opc;
    logic [PC_W-1:0] ptr;
    logic [2:0] irq;
    logic [PC_W-1:0] pc;
  } pmm_row_type;
  logic mclk, rst, pclk, oe, busy, refused;
  pmm_op_type op;
  logic [WORD_W-1:0] opcode, instr, tbuf, w;
  logic [PC_W-1:0] ptr, pc;
  logic [2:0] irq;
  logic [MODE_W-1:0] mode;
  logic [BYTE_W-1:0] drv, bout, bin;
  int bad_count = 0;
  int n_compared = 0;
  pmm_row_type rows[13];
  // ----------------------------------------
  // design, programmer and shared byte bus
  // ----------------------------------------
  assign bin = oe ? bout : drv;
  pmm_core #(.DEPTH(SIZE_FULL)) dut_u (.MCLK(mclk), .RST(rst), .OP(op), .OPCODE(opcode),
    .ADDR_POINTER_REG(ptr), .IRQ_SEL(irq), .PROG_MODE_SELECT(mode), .PROG_CLK(pclk),
    .PROG_BYTE_BUS_IN(bin), .PROG_BYTE_BUS_OUT(bout), .PROG_BYTE_BUS_OE(oe), .PC(pc),
    .INSTR(instr), .TRANSFER_BUFFER(tbuf), .TABLE_BUSY(busy), .CALL_REFUSED(refused));
  pmm_prog_model prog_u (.clk(mclk), .mode(mode), .pclk(pclk), .drv(drv));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [WORD_W-1:0] pat(input logic [PC_W-1:0] a);
    return {a[3:0], ~a};
  endfunction
  task automatic fail(input string m);
    bad_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock and watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // full write pass needs about 66k cycles
  initial begin
    repeat (90000) @(posedge mclk);
    fail("watchdog expired");
    close_out();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rows = '{
      '{OP_BRANCH_IND, 16'h0000, 12'hFFF, 3'h0, 12'hFFF},
      '{OP_NEXT, 16'h0000, 12'h000, 3'h0, 12'h000},
      '{OP_BRANCH_DIRECT, 16'hC7FF, 12'h000, 3'h0, 12'h7FF},
      '{OP_BRANCH_DIRECT, 16'hD001, 12'h000, 3'h0, 12'h801},
      '{OP_CALL_DIRECT, 16'h07FF, 12'h000, 3'h0, 12'h7FF},
      '{OP_CALL_IND, 16'h0000, 12'hA5A, 3'h0, 12'hA5A},
      '{OP_HOLD, 16'h0000, 12'h000, 3'h0, 12'hA5A},
      '{OP_IRQ, 16'h0000, 12'h000, 3'h0, VEC_SERIAL},
      '{OP_IRQ, 16'h0000, 12'h000, 3'h1, VEC_INTERVAL},
      '{OP_IRQ, 16'h0000, 12'h000, 3'h2, VEC_TIMER1},
      '{OP_IRQ, 16'h0000, 12'h000, 3'h3, VEC_TIMER0},
      '{OP_IRQ, 16'h0000, 12'h000, 3'h4, VEC_EXTERNAL},
      '{OP_IRQ, 16'h0000, 12'h000, 3'h7, VEC_EXTERNAL}
    };
    rst = 1'b1;
    op = OP_HOLD;
    opcode = 16'h0000;
    ptr = 12'h000;
    irq = 3'h0;
    repeat (16) @(posedge mclk);
    n_compared++;
    if (!(pc === VEC_RESET && oe === 1'b0)) begin
      fail("reset state");
    end
    $display("test reset done");
    rst <= 1'b0;
    prog_u.set_mode(MODE_CLEAR);
    prog_u.set_mode(MODE_WRITE);
    for (int a = 0; a < SIZE_FULL; a++) begin
      prog_u.put_word(pat(a[PC_W-1:0]));
    end
    prog_u.set_mode(MODE_CLEAR);
    prog_u.set_mode(MODE_VERIFY);
    w = pat(12'h000);
    n_compared++;
    if (!(oe === 1'b1 && bout === w[7:0])) begin
      fail("verify low byte");
    end
    prog_u.pulse(8'h00, 1'b0);
    n_compared++;
    if (!(bout === w[15:8])) begin
      fail("verify high byte");
    end
    prog_u.pulse(8'h00, 1'b0);
    w = pat(12'h001);
    n_compared++;
    if (!(bout === w[7:0])) begin
      fail("verify next word");
    end
    prog_u.set_mode(MODE_IDLE);
    $display("test write and verify done");
    foreach (rows[i]) begin
      @(posedge mclk);
      op <= rows[i].op;
      opcode <= rows[i].opc;
      ptr <= rows[i].ptr;
      irq <= rows[i].irq;
      @(posedge mclk);
      op <= OP_HOLD;
      #1;
      w = pat(rows[i].pc);
      n_compared++;
      if (!(pc === rows[i].pc && instr === w && refused === 1'b0)) begin
        fail($sformatf("fetch row %0d", i));
      end
    end
    $display("test fetch rows done");
    @(posedge mclk);
    op <= OP_BRANCH_IND;
    ptr <= 12'h010;
    @(posedge mclk);
    op <= OP_TABLE;
    ptr <= 12'hFFF;
    @(posedge mclk);
    op <= OP_NEXT;
    #1;
    n_compared++;
    if (!(busy === 1'b1 && pc === 12'h010)) begin
      fail("table first cycle");
    end
    @(posedge mclk);
    op <= OP_HOLD;
    #1;
    w = pat(12'hFFF);
    n_compared++;
    if (!(busy === 1'b0 && tbuf === w && pc === 12'h011)) begin
      fail("table result");
    end
    $display("test table read done");
    prog_u.set_mode(MODE_VERIFY);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    #1;
    n_compared++;
    if (!(pc === VEC_RESET && oe === 1'b0 && busy === 1'b0)) begin
      fail("second reset");
    end
    // release again and follow the first two fetches
    @(posedge mclk);
    rst <= 1'b0;
    op <= OP_NEXT;
    @(posedge mclk);
    #1;
    w = pat(12'h001);
    n_compared++;
    if (!(pc === 12'h001 && instr === w)) begin
      fail("first fetch after reset");
    end
    @(posedge mclk);
    #1;
    n_compared++;
    if (!(pc === 12'h002 && busy === 1'b0)) begin
      fail("second fetch after reset");
    end
    $display("test second reset done");
    close_out();
  end
endmodule
